//--- src/pack_alarm_pkg.sv
// pack state codes, command codes, field layout and reset values for the pack state block
// assumes one system clock; the bus front end and the gauge core share that clock
// How it works
// - state code readable in status word
// - each pack state maps to fixed code
// - charge switch on above discharge detect current
// - fixed pack keeps the opposite switch on in AFE and overcurrent failures
// - wakeup/precharge: charge switch on if config 01
// - precharge: config 00 zero-volt, 02 precharge switch
// - capacity below threshold raises alarm message
// - zero capacity threshold disables its alarm
// - capacity threshold loads from flash 0x02-0x03
// - capacity threshold holds until host write
// - capacity threshold unsigned 16 bits, unit selectable
// - commands 0x01 and 0x02, word read/write
// - time to empty below threshold raises alarm
// - zero time threshold disables its alarm
// - time threshold loads from flash 0x00-0x01
// - time threshold holds until host write
// - time threshold unsigned 16-bit minutes
// - status word: switches, failure cause, state code
package pack_alarm_pkg;

	// command codes on the word port
	localparam logic [7:0] CMD_MFG_ACCESS = 8'h00;
	localparam logic [7:0] CMD_CAP_ALARM = 8'h01;
	localparam logic [7:0] CMD_TIME_ALARM = 8'h02;
	localparam logic [15:0] SUBCMD_MFG_STATUS = 16'h0004;

	// status word layout
	localparam int SW_FIELD_LSB = 14;
	localparam int PF_FIELD_LSB = 12;
	localparam int CODE_FIELD_LSB = 8;
	localparam logic [7:0] STATUS_LOW_BYTE = 8'h0a;

	// reported state codes
	localparam logic [3:0] CODE_WAKEUP = 4'h0;
	localparam logic [3:0] CODE_NORMAL = 4'h1;
	localparam logic [3:0] CODE_PRECHARGE = 4'h3;
	localparam logic [3:0] CODE_CHG_SUSP = 4'h4;
	localparam logic [3:0] CODE_CHARGE = 4'h5;
	localparam logic [3:0] CODE_CHG_TERM = 4'h7;
	localparam logic [3:0] CODE_FAULT_TERM = 4'h8;
	localparam logic [3:0] CODE_PERM_FAIL = 4'h9;
	localparam logic [3:0] CODE_OVER_CURRENT = 4'ha;
	localparam logic [3:0] CODE_BATT_FAIL = 4'hc;
	localparam logic [3:0] CODE_SLEEP = 4'hd;
	localparam logic [3:0] CODE_SYS_PRESENT = 4'he;
	localparam logic [3:0] CODE_BATT_OUT = 4'hf;

	// switch configuration values
	localparam logic [1:0] CFG_ZERO_VOLT = 2'h0;
	localparam logic [1:0] CFG_CHG_SWITCH = 2'h1;
	localparam logic [1:0] CFG_PRECHARGE = 2'h2;

	// flash image of the thresholds, low byte at the lower address
	localparam logic [7:0] FLASH_TIME_ADDR = 8'h00;
	localparam logic [7:0] FLASH_CAP_ADDR = 8'h02;
	localparam logic [1:0] FLASH_LAST_IDX = 2'h3;

	// alarm message bits and reset values
	localparam int ALARM_CAP_BIT = 9;
	localparam int ALARM_TIME_BIT = 8;
	localparam logic [15:0] THRESH_RESET = 16'h0000;

	typedef enum logic [4:0] {
		ST_WAKEUP, ST_PRECHARGE, ST_CHG_SUSP, ST_TERM_CHG, ST_NORMAL_CHG, ST_PROVISIONAL_CHG,
		ST_NORMAL_DSG, ST_DEPLETED, ST_DEPLETED_AC, ST_OVERHEAT_DSG, ST_OVERHEAT_CHG,
		ST_BF_OVERCHARGE, ST_BF_LOWTEMP, ST_BF_CHGTERM, ST_BF_AFE_CHG, ST_BF_AFE_DSG,
		ST_BF_CHG, ST_BF_DSG, ST_REMOVED, ST_SLEEP, ST_PERM_FAIL
	} pack_state_type;

	typedef enum {INIT_READ, INIT_WAIT, INIT_DONE} init_state_type;

endpackage

//--- src/threshold_alarm.sv
// one threshold comparator with a registered alarm flag
// assumes the update strobe and both operands come from the system clock domain
module threshold_alarm import pack_alarm_pkg::*; #(
	parameter int WIDTH = 16
) (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic update_in,
	input wire logic [WIDTH-1:0] threshold_in,
	input wire logic [WIDTH-1:0] value_in,
	output logic alarm_out
);

	// refuse a width that leaves nothing to compare
	if (WIDTH < 1) begin
		$error("threshold width must be positive");
	end

	logic alarm_next;

	// compare only on an update strobe; zero threshold never alarms
	always_comb begin
		alarm_next = alarm_out;
		if (update_in) begin
			alarm_next = (threshold_in != '0) && (value_in < threshold_in);
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			alarm_out <= 1'b0;
		end else begin
			alarm_out <= alarm_next;
		end
	end

	a_zero_disables: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		update_in && threshold_in == '0 |=> !alarm_out)
		else $error("alarm raised with zero threshold");

	a_below_sets: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		update_in && threshold_in != '0 && value_in < threshold_in |=> alarm_out)
		else $error("alarm missing below threshold");

	a_holds_between: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		!update_in |=> $stable(alarm_out))
		else $error("alarm changed without update");

endmodule

//--- src/pack_state_alarm.sv
// pack state reporting, switch drive and capacity/time alarm thresholds
// assumes a bus front end that hands over decoded word commands on the system clock,
// a gauge core that supplies state and measurements, and a byte-wide flash read port
module pack_state_alarm import pack_alarm_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	output logic [15:0] rdata_out,
	output logic rdata_valid_out,
	input wire pack_state_type pack_state_in,
	input wire logic [1:0] switch_configuration_in,
	input wire logic fixed_pack_option_in,
	input wire logic [1:0] pf_cause_in,
	input wire logic [15:0] dsg_current_in,
	input wire logic [15:0] dsg_detect_threshold_in,
	input wire logic capacity_unit_in,
	input wire logic meas_update_in,
	input wire logic [15:0] remaining_charge_in,
	input wire logic [15:0] average_time_to_empty_a_in,
	output logic flash_rd_out,
	output logic [7:0] flash_addr_out,
	input wire logic flash_valid_in,
	input wire logic [7:0] flash_data_in,
	output logic init_done_out,
	output logic alarm_warning_message_valid_out,
	output logic [15:0] alarm_warning_message_out,
	input wire logic alarm_ack_in,
	output logic charge_switch_out,
	output logic discharge_switch_out,
	output logic zero_volt_charge_switch_out,
	output logic precharge_switch_out,
	output logic fuse_blow_out,
	output logic low_power_out
);

	// state code of each pack state
	function automatic logic [3:0] code_of(pack_state_type st);
		logic [3:0] c;
		c = CODE_NORMAL;
		unique case (st)
			ST_WAKEUP: c = CODE_WAKEUP;
			ST_PRECHARGE: c = CODE_PRECHARGE;
			ST_CHG_SUSP: c = CODE_CHG_SUSP;
			ST_TERM_CHG: c = CODE_CHG_TERM;
			ST_NORMAL_CHG: c = CODE_CHARGE;
			ST_PROVISIONAL_CHG, ST_NORMAL_DSG, ST_DEPLETED, ST_DEPLETED_AC: c = CODE_NORMAL;
			ST_OVERHEAT_DSG, ST_OVERHEAT_CHG: c = CODE_SYS_PRESENT;
			ST_BF_OVERCHARGE, ST_BF_LOWTEMP, ST_BF_CHGTERM: c = CODE_FAULT_TERM;
			ST_BF_AFE_CHG, ST_BF_AFE_DSG: c = CODE_BATT_FAIL;
			ST_BF_CHG, ST_BF_DSG: c = CODE_OVER_CURRENT;
			ST_REMOVED: c = CODE_BATT_OUT;
			ST_SLEEP: c = CODE_SLEEP;
			ST_PERM_FAIL: c = CODE_PERM_FAIL;
			default: c = CODE_NORMAL;
		endcase
		return c;
	endfunction

	// switch drive of each state: {chg, dsg, zero volt, precharge, fuse, low power}
	function automatic logic [5:0] drive_of(pack_state_type st, logic [1:0] cfg, logic fixed);
		logic chg;
		logic dsg;
		logic zv;
		logic pre;
		logic fuse;
		logic lp;
		chg = 1'b0;
		dsg = 1'b1;
		zv = 1'b0;
		pre = 1'b0;
		fuse = 1'b0;
		lp = 1'b0;
		unique case (st)
			ST_WAKEUP: begin
				chg = (cfg == CFG_CHG_SWITCH);
				zv = (cfg == CFG_ZERO_VOLT) || (cfg == CFG_PRECHARGE);
			end
			ST_PRECHARGE: begin
				chg = (cfg == CFG_CHG_SWITCH);
				zv = (cfg == CFG_ZERO_VOLT);
				pre = (cfg == CFG_PRECHARGE);
			end
			ST_DEPLETED_AC: begin
				dsg = 1'b0;
				zv = (cfg == CFG_ZERO_VOLT);
				pre = (cfg == CFG_PRECHARGE);
			end
			ST_NORMAL_CHG, ST_NORMAL_DSG: chg = 1'b1;
			ST_DEPLETED, ST_OVERHEAT_DSG, ST_OVERHEAT_CHG, ST_REMOVED: dsg = 1'b0;
			ST_BF_AFE_CHG, ST_BF_CHG: dsg = fixed;
			ST_BF_AFE_DSG, ST_BF_DSG: begin
				chg = fixed;
				dsg = 1'b0;
			end
			ST_SLEEP: begin
				dsg = 1'b0;
				lp = 1'b1;
			end
			ST_PERM_FAIL: begin
				dsg = 1'b0;
				fuse = 1'b1;
				lp = 1'b1;
			end
			default: dsg = 1'b1;
		endcase
		return {chg, dsg, zv, pre, fuse, lp};
	endfunction

	// switch state field: 00 both on, 01 chg off, 10 both off, 11 dsg off
	function automatic logic [1:0] sw_field(logic chg, logic dsg);
		return {~dsg, chg ^ dsg};
	endfunction

	logic [5:0] drive;
	logic dsg_override;
	logic [3:0] pack_code_reg;
	logic [3:0] pack_code_next;
	logic [1:0] pf_cause_reg;

	// switch drive, registered every cycle
	always_comb begin
		drive = drive_of(pack_state_in, switch_configuration_in, fixed_pack_option_in);
		dsg_override = dsg_current_in > dsg_detect_threshold_in;
		drive[5] = drive[5] | dsg_override;
		pack_code_next = code_of(pack_state_in);
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			charge_switch_out <= 1'b0;
			discharge_switch_out <= 1'b0;
			zero_volt_charge_switch_out <= 1'b0;
			precharge_switch_out <= 1'b0;
			fuse_blow_out <= 1'b0;
			low_power_out <= 1'b0;
			pack_code_reg <= CODE_WAKEUP;
			pf_cause_reg <= 2'h0;
		end else begin
			charge_switch_out <= drive[5];
			discharge_switch_out <= drive[4];
			zero_volt_charge_switch_out <= drive[3];
			precharge_switch_out <= drive[2];
			fuse_blow_out <= drive[1];
			low_power_out <= drive[0];
			pack_code_reg <= pack_code_next;
			pf_cause_reg <= pf_cause_in;
		end
	end

	init_state_type init_state_reg;
	init_state_type init_state_next;
	logic [1:0] byte_idx_reg;
	logic [1:0] byte_idx_next;
	logic flash_rd_next;
	logic [7:0] flash_addr_next;
	logic [15:0] cap_thresh_reg;
	logic [15:0] cap_thresh_next;
	logic [15:0] time_thresh_reg;
	logic [15:0] time_thresh_next;
	logic cap_host_reg;
	logic cap_host_next;
	logic time_host_reg;
	logic time_host_next;
	logic [15:0] mfg_word_reg;
	logic [15:0] mfg_word_next;
	logic wr_cap;
	logic wr_time;
	logic wr_mfg;

	// flash load sequence and host writes to the thresholds
	always_comb begin
		init_state_next = init_state_reg;
		byte_idx_next = byte_idx_reg;
		flash_rd_next = 1'b0;
		flash_addr_next = flash_addr_out;
		cap_thresh_next = cap_thresh_reg;
		time_thresh_next = time_thresh_reg;
		cap_host_next = cap_host_reg;
		time_host_next = time_host_reg;
		mfg_word_next = mfg_word_reg;
		wr_cap = cmd_valid_in && cmd_write_in && cmd_code_in == CMD_CAP_ALARM;
		wr_time = cmd_valid_in && cmd_write_in && cmd_code_in == CMD_TIME_ALARM;
		wr_mfg = cmd_valid_in && cmd_write_in && cmd_code_in == CMD_MFG_ACCESS;
		unique case (init_state_reg)
			INIT_READ: begin
				flash_rd_next = 1'b1;
				flash_addr_next = FLASH_TIME_ADDR | {6'h00, byte_idx_reg};
				init_state_next = INIT_WAIT;
			end
			INIT_WAIT: begin
				if (flash_valid_in) begin
					unique case (byte_idx_reg)
						2'h0: if (!time_host_reg) time_thresh_next[7:0] = flash_data_in;
						2'h1: if (!time_host_reg) time_thresh_next[15:8] = flash_data_in;
						2'h2: if (!cap_host_reg) cap_thresh_next[7:0] = flash_data_in;
						2'h3: if (!cap_host_reg) cap_thresh_next[15:8] = flash_data_in;
					endcase
					if (byte_idx_reg == FLASH_LAST_IDX) begin
						init_state_next = INIT_DONE;
					end else begin
						byte_idx_next = byte_idx_reg + 2'h1;
						init_state_next = INIT_READ;
					end
				end
			end
			INIT_DONE: init_state_next = INIT_DONE;
		endcase
		// a host write wins over flash and is kept until the next write
		if (wr_cap) begin
			cap_thresh_next = cmd_wdata_in;
			cap_host_next = 1'b1;
		end
		if (wr_time) begin
			time_thresh_next = cmd_wdata_in;
			time_host_next = 1'b1;
		end
		if (wr_mfg) begin
			mfg_word_next = cmd_wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			init_state_reg <= INIT_READ;
			byte_idx_reg <= 2'h0;
			flash_rd_out <= 1'b0;
			flash_addr_out <= FLASH_TIME_ADDR;
			init_done_out <= 1'b0;
			cap_thresh_reg <= THRESH_RESET;
			time_thresh_reg <= THRESH_RESET;
			cap_host_reg <= 1'b0;
			time_host_reg <= 1'b0;
			mfg_word_reg <= 16'h0000;
		end else begin
			init_state_reg <= init_state_next;
			byte_idx_reg <= byte_idx_next;
			flash_rd_out <= flash_rd_next;
			flash_addr_out <= flash_addr_next;
			init_done_out <= (init_state_next == INIT_DONE);
			cap_thresh_reg <= cap_thresh_next;
			time_thresh_reg <= time_thresh_next;
			cap_host_reg <= cap_host_next;
			time_host_reg <= time_host_next;
			mfg_word_reg <= mfg_word_next;
		end
	end

	logic [15:0] rdata_next;
	logic rd_cmd;

	// word reads answered one cycle after the command
	always_comb begin
		rd_cmd = cmd_valid_in && !cmd_write_in;
		rdata_next = rdata_out;
		if (rd_cmd) begin
			unique case (cmd_code_in)
				CMD_CAP_ALARM: rdata_next = cap_thresh_reg;
				CMD_TIME_ALARM: rdata_next = time_thresh_reg;
				CMD_MFG_ACCESS: begin
					if (mfg_word_reg == SUBCMD_MFG_STATUS) begin
						rdata_next = {sw_field(charge_switch_out, discharge_switch_out), pf_cause_reg,
							pack_code_reg, STATUS_LOW_BYTE};
					end else begin
						rdata_next = 16'h0000;
					end
				end
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_out <= 16'h0000;
			rdata_valid_out <= 1'b0;
		end else begin
			rdata_out <= rdata_next;
			rdata_valid_out <= rd_cmd;
		end
	end

	logic unit_reg;
	logic cmp_update;
	logic upd_d_reg;
	logic cap_alarm;
	logic time_alarm;
	logic alarm_set;
	logic alarm_valid_next;
	logic [15:0] alarm_word_next;

	// a unit change re-evaluates the capacity compare at once
	assign cmp_update = meas_update_in || (capacity_unit_in != unit_reg);

	threshold_alarm #(.WIDTH(16)) u_cap_alarm (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.update_in(cmp_update),
		.threshold_in(cap_thresh_reg),
		.value_in(remaining_charge_in),
		.alarm_out(cap_alarm)
	);

	threshold_alarm #(.WIDTH(16)) u_time_alarm (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.update_in(cmp_update),
		.threshold_in(time_thresh_reg),
		.value_in(average_time_to_empty_a_in),
		.alarm_out(time_alarm)
	);

	// alarm message held until acknowledged; a new alarm beats the ack
	always_comb begin
		alarm_set = upd_d_reg && (cap_alarm || time_alarm);
		alarm_valid_next = alarm_set || (alarm_warning_message_valid_out && !alarm_ack_in);
		alarm_word_next = alarm_warning_message_out;
		if (alarm_set) begin
			alarm_word_next = 16'h0000;
			alarm_word_next[ALARM_CAP_BIT] = cap_alarm;
			alarm_word_next[ALARM_TIME_BIT] = time_alarm;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			unit_reg <= 1'b0;
			upd_d_reg <= 1'b0;
			alarm_warning_message_valid_out <= 1'b0;
			alarm_warning_message_out <= 16'h0000;
		end else begin
			unit_reg <= capacity_unit_in;
			upd_d_reg <= cmp_update;
			alarm_warning_message_valid_out <= alarm_valid_next;
			alarm_warning_message_out <= alarm_word_next;
		end
	end

	a_status_code: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		rd_cmd && cmd_code_in == CMD_MFG_ACCESS && mfg_word_reg == SUBCMD_MFG_STATUS
		|=> rdata_valid_out && rdata_out[11:8] == $past(pack_code_reg) && rdata_out[7:0] == STATUS_LOW_BYTE)
		else $error("status word code field wrong");

	a_sleep_code: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		pack_state_in == ST_SLEEP |=> pack_code_reg == CODE_SLEEP)
		else $error("sleep code wrong");

	a_dsg_override: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		dsg_current_in > dsg_detect_threshold_in |=> charge_switch_out)
		else $error("charge switch off above detect current");

	a_fixed_keeps_on: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		fixed_pack_option_in && (pack_state_in == ST_BF_AFE_CHG || pack_state_in == ST_BF_CHG)
		|=> discharge_switch_out)
		else $error("fixed pack lost discharge switch");

	a_wake_chg_off: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		pack_state_in == ST_WAKEUP && switch_configuration_in != CFG_CHG_SWITCH
		&& dsg_current_in <= dsg_detect_threshold_in |=> !charge_switch_out)
		else $error("charge switch on in wakeup");

	a_precharge_path: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		pack_state_in == ST_PRECHARGE && switch_configuration_in == CFG_PRECHARGE
		|=> precharge_switch_out && !zero_volt_charge_switch_out)
		else $error("precharge path wrong");

	a_pf_shutdown: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		pack_state_in == ST_PERM_FAIL |=> !discharge_switch_out && fuse_blow_out && low_power_out)
		else $error("permanent failure drive wrong");

	a_cap_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		init_done_out && !wr_cap |=> $stable(cap_thresh_reg))
		else $error("capacity threshold changed without write");

	a_time_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		wr_time |=> time_thresh_reg == $past(cmd_wdata_in))
		else $error("time threshold write lost");

	a_cap_flash: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		init_state_reg == INIT_WAIT && flash_valid_in && byte_idx_reg == 2'h3 && !cap_host_reg && !wr_cap
		|=> cap_thresh_reg[15:8] == $past(flash_data_in) ##1 init_done_out)
		else $error("capacity flash load wrong");

	a_time_flash: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		init_state_reg == INIT_WAIT && flash_valid_in && byte_idx_reg == 2'h0 && !time_host_reg && !wr_time
		|=> time_thresh_reg[7:0] == $past(flash_data_in))
		else $error("time flash load wrong");

	a_alarm_msg: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		upd_d_reg && cap_alarm |=> alarm_warning_message_valid_out && alarm_warning_message_out[ALARM_CAP_BIT])
		else $error("capacity alarm message missing");

endmodule

//--- test/flash_model.sv
// data flash responder that answers the threshold load at start-up
// assumes one byte request at a time; the answer delay is sampled when a request arrives
module flash_model (
	input wire logic clk_sys_in,
	input wire logic flash_rd_in,
	input wire logic [7:0] flash_addr_in,
	input wire logic [31:0] image_in,
	input wire logic [3:0] delay_in,
	output logic flash_valid_out,
	output logic [7:0] flash_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] addr_reg;
	int wait_cnt = -1;
	initial flash_valid_out = 1'b0;
	initial flash_data_out = 8'h00;
	// answer each request once after its delay; the data line churns whenever it is not valid
	always @(posedge clk_sys_in) begin
		flash_valid_out <= 1'b0;
		flash_data_out <= ~flash_data_out;
		if (flash_rd_in) begin
			addr_reg <= flash_addr_in;
			wait_cnt <= int'(delay_in);
		end else if (wait_cnt == 0) begin
			flash_valid_out <= 1'b1;
			flash_data_out <= image_in[addr_reg[1:0] * 8 +: 8];
			wait_cnt <= -1;
		end else if (wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
		end
	end
endmodule

//--- test/tb_top.sv
// self-checking bench for the pack state and alarm threshold block
// assumes the flash responder model beside the design and one free-running system clock
module tb_top import pack_alarm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, cmd_valid_in = 1'b0, cmd_write_in = 1'b0;
	logic [7:0] cmd_code_in = 8'h00, flash_addr_out, flash_data_in;
	logic [15:0] cmd_wdata_in = 16'h0000, rdata_out, alarm_warning_message_out;
	logic [15:0] dsg_current_in = 16'h0000, dsg_detect_threshold_in = 16'hffff;
	logic [15:0] remaining_charge_in = 16'hffff, average_time_to_empty_a_in = 16'hffff;
	logic [1:0] switch_configuration_in = 2'h0, pf_cause_in = 2'h0;
	logic fixed_pack_option_in = 1'b0, capacity_unit_in = 1'b0, meas_update_in = 1'b0, alarm_ack_in = 1'b0;
	logic rdata_valid_out, flash_rd_out, flash_valid_in, init_done_out, alarm_warning_message_valid_out;
	logic charge_switch_out, discharge_switch_out, zero_volt_charge_switch_out, precharge_switch_out;
	logic fuse_blow_out, low_power_out;
	logic [5:0] sw_seen;
	pack_state_type pack_state_in = ST_NORMAL_DSG;
	logic [31:0] image = 32'h0000_0000;
	logic [3:0] delay = 4'h3;
	int errors = 0, total_checks = 0;
	logic [3:0] code_tab [21] = '{4'h0, 4'h3, 4'h4, 4'h7, 4'h5, 4'h1, 4'h1, 4'h1, 4'h1, 4'he, 4'he, 4'h8, 4'h8,
		4'h8, 4'hc, 4'hc, 4'ha, 4'ha, 4'hf, 4'hd, 4'h9};

	// 250 MHz system clock
	initial forever #2 clk_sys_in = ~clk_sys_in;

	pack_state_alarm DUT (.clk_sys_in, .sys_rst_in, .cmd_valid_in, .cmd_write_in, .cmd_code_in, .cmd_wdata_in,
		.rdata_out, .rdata_valid_out, .pack_state_in, .switch_configuration_in, .fixed_pack_option_in, .pf_cause_in,
		.dsg_current_in, .dsg_detect_threshold_in, .capacity_unit_in, .meas_update_in, .remaining_charge_in,
		.average_time_to_empty_a_in, .flash_rd_out, .flash_addr_out, .flash_valid_in, .flash_data_in, .init_done_out,
		.alarm_warning_message_valid_out, .alarm_warning_message_out, .alarm_ack_in, .charge_switch_out,
		.discharge_switch_out, .zero_volt_charge_switch_out, .precharge_switch_out, .fuse_blow_out, .low_power_out);

	flash_model partner (.clk_sys_in, .flash_rd_in(flash_rd_out), .flash_addr_in(flash_addr_out), .image_in(image),
		.delay_in(delay), .flash_valid_out(flash_valid_in), .flash_data_out(flash_data_in));

	// switch drive gathered as chg, dsg, zero-volt, precharge, fuse, low power
	assign sw_seen = {charge_switch_out, discharge_switch_out, zero_volt_charge_switch_out, precharge_switch_out,
		fuse_blow_out, low_power_out};

	// expected switch drive for a state, configuration, fixed-pack option and current override
	function automatic logic [5:0] exp_sw(pack_state_type s, logic [1:0] c, logic f, logic o);
		logic [5:0] e;
		case (s)
			ST_WAKEUP: e = {c == CFG_CHG_SWITCH, 1'b1, c != CFG_CHG_SWITCH, 3'h0};
			ST_PRECHARGE, ST_DEPLETED_AC: e = {s == ST_PRECHARGE && c == CFG_CHG_SWITCH, s == ST_PRECHARGE,
				c == CFG_ZERO_VOLT, c == CFG_PRECHARGE, 2'h0};
			ST_NORMAL_CHG, ST_NORMAL_DSG: e = 6'h30;
			ST_CHG_SUSP, ST_TERM_CHG, ST_PROVISIONAL_CHG, ST_BF_OVERCHARGE, ST_BF_LOWTEMP, ST_BF_CHGTERM: e = 6'h10;
			ST_BF_AFE_CHG, ST_BF_CHG: e = {1'b0, f, 4'h0};
			ST_BF_AFE_DSG, ST_BF_DSG: e = {f, 5'h00};
			ST_SLEEP: e = 6'h01;
			ST_PERM_FAIL: e = 6'h03;
			default: e = 6'h00;
		endcase
		e[5] = e[5] | o;
		return e;
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// a write leaves the request up so that a following read comes back to back
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(posedge clk_sys_in);
		cmd_valid_in <= 1'b1;
		cmd_write_in <= 1'b1;
		cmd_code_in <= code;
		cmd_wdata_in <= data;
	endtask

	// read word; the one-cycle answer is looked at in the cycle after the taking edge
	task automatic rd(input string what, input logic [7:0] code, input logic [15:0] exp);
		@(posedge clk_sys_in);
		cmd_valid_in <= 1'b1;
		cmd_write_in <= 1'b0;
		cmd_code_in <= code;
		@(posedge clk_sys_in);
		cmd_valid_in <= 1'b0;
		@(negedge clk_sys_in);
		chk({what, " valid"}, 16'h0001, {15'h0000, rdata_valid_out});
		chk(what, exp, rdata_out);
	endtask

	// one measurement update or unit change, then the pending message, its hold and its ack
	task automatic pulse(input logic by_unit, input logic [15:0] rem, input logic [15:0] tte, input logic c,
		input logic t);
		chk("alarm idle", 16'h0000, {15'h0000, alarm_warning_message_valid_out});
		@(posedge clk_sys_in);
		remaining_charge_in <= rem;
		average_time_to_empty_a_in <= tte;
		if (by_unit) capacity_unit_in <= ~capacity_unit_in;
		else meas_update_in <= 1'b1;
		@(posedge clk_sys_in);
		meas_update_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk("alarm valid", {15'h0000, c | t}, {15'h0000, alarm_warning_message_valid_out});
		if (c | t) begin
			chk("alarm word", {6'h00, c, t, 8'h00}, alarm_warning_message_out);
			repeat (2) @(posedge clk_sys_in);
			@(negedge clk_sys_in);
			chk("alarm held", 16'h0001, {15'h0000, alarm_warning_message_valid_out});
			@(posedge clk_sys_in);
			alarm_ack_in <= 1'b1;
			@(posedge clk_sys_in);
			alarm_ack_in <= 1'b0;
			@(negedge clk_sys_in);
			chk("alarm cleared", 16'h0000, {15'h0000, alarm_warning_message_valid_out});
		end
	endtask

	task automatic close_out();
		if (errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected several hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		errors++;
		close_out();
	end

	// main sequence: flash load, threshold traffic and alarms, then every pack state
	initial begin
		logic [15:0] cap, tim, rem, tte, thr, cur;
		logic [5:0] e;
		logic [1:0] cfg, pf;
		logic fx;
		void'($urandom(49792));
		image = $urandom;
		repeat (16) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 400 && init_done_out !== 1'b1; i++) begin
			@(posedge clk_sys_in);
			delay <= 4'($urandom);
		end
		chk("init done", 16'h0001, {15'h0000, init_done_out});
		rd("time threshold", CMD_TIME_ALARM, image[15:0]);
		rd("capacity threshold", CMD_CAP_ALARM, image[31:16]);
		rd("unknown code", 8'h05, 16'h0000);
		rd("status unselected", CMD_MFG_ACCESS, 16'h0000);
		for (int r = 0; r < 24; r++) begin
			cap = $urandom;
			tim = $urandom;
			rem = $urandom;
			tte = $urandom;
			if (r % 4 < 2) rem = cap - 16'(r % 4);
			if (r % 4 == 1) tte = tim - 16'h0001;
			if (r % 4 == 3) {cap, tim} = 32'h0000_0000;
			wr(CMD_CAP_ALARM, cap);
			rd("capacity readback", CMD_CAP_ALARM, cap);
			wr(CMD_TIME_ALARM, tim);
			rd("time readback", CMD_TIME_ALARM, tim);
			pulse(1'b0, rem, tte, cap != 0 && rem < cap, tim != 0 && tte < tim);
		end
		wr(CMD_CAP_ALARM, 16'h8000);
		rd("capacity readback", CMD_CAP_ALARM, 16'h8000);
		wr(8'h05, 16'h1234);
		rd("capacity after stray write", CMD_CAP_ALARM, 16'h8000);
		pulse(1'b1, 16'h7fff, 16'hffff, 1'b1, 1'b0);
		wr(CMD_MFG_ACCESS, SUBCMD_MFG_STATUS);
		for (int i = 0; i < 63; i++) begin
			cfg = 2'($urandom_range(2));
			fx = 1'($urandom);
			pf = 2'($urandom);
			thr = 16'($urandom_range(16'hfffe));
			cur = (i % 3 == 0) ? thr >> 1 : thr + 16'($urandom_range(1));
			e = exp_sw(pack_state_type'(i % 21), cfg, fx, cur > thr);
			@(posedge clk_sys_in);
			pack_state_in <= pack_state_type'(i % 21);
			switch_configuration_in <= cfg;
			fixed_pack_option_in <= fx;
			pf_cause_in <= pf;
			dsg_detect_threshold_in <= thr;
			dsg_current_in <= cur;
			repeat (2) @(posedge clk_sys_in);
			@(negedge clk_sys_in);
			chk("switches", {10'h000, e}, {10'h000, sw_seen});
			rd("status word", CMD_MFG_ACCESS, {~e[4], e[5] ^ e[4], pf, code_tab[i % 21], 8'h0a});
		end
		close_out();
	end
endmodule
